// ==== common/eipb_defs.vh ====
/*
  Constants for the extended interrupt priority bank: SFR addresses, bit positions,
  reset values.
  Assumes an 8051-style core SFR bus with 8-bit address and data.
*/
// What this block does
// - priority register is eight-bit read/write SFR at address 0xF6
// - bit 7 sets timer 3 priority, zero low, one high
// - bit 6 sets comparator 1 priority, zero low, one high
// - bit 5 sets comparator 0 priority, zero low, one high
// - bit 4 sets counter array priority, zero low, one high
// - bit 3 sets conversion-complete priority, zero low, one high
// - bit 2 sets window-compare priority, zero low, one high
`ifndef EIPB_DEFS_VH
`define EIPB_DEFS_VH
`define EIPB_ADDR_PRIO_ONE     8'hF6
`define EIPB_ADDR_ENABLE_TWO   8'hE7
`define EIPB_RST_PRIO_ONE      8'h00
`define EIPB_RST_ENABLE_TWO    8'h00
`define EIPB_ENABLE_TWO_MASK   8'h03
`define EIPB_BIT_TIMER3        7
`define EIPB_BIT_CMP_B         6
`define EIPB_BIT_CMP_A         5
`define EIPB_BIT_PCA           4
`define EIPB_BIT_CONV          3
`define EIPB_BIT_WINDOW        2
`define EIPB_BIT_USB           1
`define EIPB_BIT_TWOWIRE       0
`define EIPB_BIT_SERIAL2       1
`define EIPB_BIT_SUPPLY        0
`endif

// ==== logic/eipb_sfr_reg.v ====
/*
  One 8-bit SFR register with address match and writable-bit mask.
  Assumes writes are single-cycle strobes from the core on clk_sys.
*/
`timescale 1ns/1ps
module eipb_sfr_reg #(
  parameter [7:0] ADDR     = 8'h00,
  parameter [7:0] RST_VAL  = 8'h00,
  parameter [7:0] WR_MASK  = 8'hFF
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // sfr write side
  input  wire       sfr_wr,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  // address match and register contents
  output wire       hit,
  output reg  [7:0] value_reg
);
  reg [7:0] value_next;
  assign hit = (sfr_addr == ADDR);
  always @* begin
    value_next = value_reg;
    if (sfr_wr && hit) begin
      value_next = sfr_wdata & WR_MASK;
    end
  end
  always @(posedge clk_sys) begin
    if (!resetn) begin
      value_reg <= RST_VAL;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule // eipb_sfr_reg

// ==== logic/eipb_bank.v ====
/*
  Extended interrupt priority bank: priority register and second enable register.
  Assumes the core drives sfr_wr/sfr_rd for one cycle with a stable address.
*/
`timescale 1ns/1ps
`include "eipb_defs.vh"
module eipb_bank (
  // clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // sfr bus from the core
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  output wire       sfr_hit,
  // priority levels to the arbiter, one means high
  output wire       timer_three_priority,
  output wire       comparator_b_priority,
  output wire       comparator_a_priority,
  output wire       counter_array_priority,
  output wire       conversion_done_priority,
  output wire       window_compare_priority,
  output wire       usb_irq_priority,
  output wire       twowire_bus_priority,
  // second extended enables
  output wire       second_serial_irq_enable,
  output wire       supply_level_irq_enable
);
  wire [7:0] extended_irq_priority_one;
  wire [7:0] extended_irq_enable_two;
  wire       hit_prio;
  wire       hit_en;
  reg  [7:0] sfr_rdata_next;

  eipb_sfr_reg #(
    .ADDR    (`EIPB_ADDR_PRIO_ONE),
    .RST_VAL (`EIPB_RST_PRIO_ONE),
    .WR_MASK (8'hFF)
  ) u_prio_one (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .hit       (hit_prio),
    .value_reg (extended_irq_priority_one)
  );

  // unused upper enable bits are not stored, so they read zero
  eipb_sfr_reg #(
    .ADDR    (`EIPB_ADDR_ENABLE_TWO),
    .RST_VAL (`EIPB_RST_ENABLE_TWO),
    .WR_MASK (`EIPB_ENABLE_TWO_MASK)
  ) u_enable_two (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .hit       (hit_en),
    .value_reg (extended_irq_enable_two)
  );

  assign sfr_hit                  = hit_prio | hit_en;
  assign timer_three_priority     = extended_irq_priority_one[`EIPB_BIT_TIMER3];
  assign comparator_b_priority    = extended_irq_priority_one[`EIPB_BIT_CMP_B];
  assign comparator_a_priority    = extended_irq_priority_one[`EIPB_BIT_CMP_A];
  assign counter_array_priority   = extended_irq_priority_one[`EIPB_BIT_PCA];
  assign conversion_done_priority = extended_irq_priority_one[`EIPB_BIT_CONV];
  assign window_compare_priority  = extended_irq_priority_one[`EIPB_BIT_WINDOW];
  assign usb_irq_priority         = extended_irq_priority_one[`EIPB_BIT_USB];
  assign twowire_bus_priority     = extended_irq_priority_one[`EIPB_BIT_TWOWIRE];
  assign second_serial_irq_enable = extended_irq_enable_two[`EIPB_BIT_SERIAL2];
  assign supply_level_irq_enable  = extended_irq_enable_two[`EIPB_BIT_SUPPLY];

  // read data registered; unmapped addresses return zero
  always @* begin
    sfr_rdata_next = 8'h00;
    if (sfr_rd && hit_prio) begin
      sfr_rdata_next = extended_irq_priority_one;
    end else if (sfr_rd && hit_en) begin
      sfr_rdata_next = extended_irq_enable_two;
    end
  end
  always @(posedge clk_sys) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= sfr_rdata_next;
    end
  end
endmodule // eipb_bank

// ==== verif/eipb_bank_checker.sv ====
/* Checker for the priority bank, bound to eipb_bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module eipb_bank_checker (
  // clock, reset and sfr bus
  input logic       clk_sys, resetn, sfr_wr, sfr_rd,
  input logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  input logic       sfr_hit,
  // priority levels
  input logic       timer_three_priority, comparator_b_priority, comparator_a_priority, counter_array_priority,
  input logic       conversion_done_priority, window_compare_priority, usb_irq_priority, twowire_bus_priority
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire [7:0] prio = {timer_three_priority, comparator_b_priority, comparator_a_priority, counter_array_priority,
                     conversion_done_priority, window_compare_priority, usb_irq_priority, twowire_bus_priority};
  sequence s_wr; sfr_wr && sfr_addr == 8'hF6; endsequence
  // a write in the same cycle would race the old value
  sequence s_rd; sfr_rd && !sfr_wr && sfr_addr == 8'hF6; endsequence
  property p_bit(int b, logic o); s_wr |=> o == $past(sfr_wdata[b]); endproperty
  a_read_back: assert property (s_rd |=> sfr_rdata == $past(prio)) else $error("read back");
  a_timer_prio: assert property (p_bit(7, timer_three_priority)) else $error("bit 7");
  a_cmp_b_prio: assert property (p_bit(6, comparator_b_priority)) else $error("bit 6");
  a_cmp_a_prio: assert property (p_bit(5, comparator_a_priority)) else $error("bit 5");
  a_counter_prio: assert property (p_bit(4, counter_array_priority)) else $error("bit 4");
  a_conv_prio: assert property (p_bit(3, conversion_done_priority)) else $error("bit 3");
  a_window_prio: assert property (p_bit(2, window_compare_priority)) else $error("bit 2");
  a_usb_prio: assert property (p_bit(1, usb_irq_priority)) else $error("bit 1");
  a_twowire_prio: assert property (p_bit(0, twowire_bus_priority)) else $error("bit 0");
  a_hit_decode: assert property (sfr_hit == (sfr_addr == 8'hF6 || sfr_addr == 8'hE7)) else $error("hit decode");
  a_unmapped_read: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("unmapped read");
  a_wr_holds: assert property (!(sfr_wr && sfr_addr == 8'hF6) |=> $stable(prio)) else $error("prio changed");
endmodule // eipb_bank_checker
bind eipb_bank eipb_bank_checker i_chk (.*);

// ==== verif/extended_interrupt_priority_bank_tb_top.sv ====
/* Self-checking bench for eipb_bank.
   Assumes the core strobes sfr_wr/sfr_rd for one cycle. */
`timescale 1ns/1ps
module extended_interrupt_priority_bank_tb_top;
  logic       clk_sys = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, d;
  wire  [7:0] sfr_rdata, p;
  wire  [1:0] en;
  wire        sfr_hit;
  int         bad_count = 0, n_compared = 0;
  eipb_bank i_eipb_bank (.clk_sys, .resetn, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit,
    .timer_three_priority(p[7]), .comparator_b_priority(p[6]), .comparator_a_priority(p[5]),
    .counter_array_priority(p[4]), .conversion_done_priority(p[3]), .window_compare_priority(p[2]),
    .usb_irq_priority(p[1]), .twowire_bus_priority(p[0]), .second_serial_irq_enable(en[1]),
    .supply_level_irq_enable(en[0]));
  initial forever #2.5 clk_sys = ~clk_sys;
  task chk(string nm, logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, dt);
    @(posedge clk_sys) #1;
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, dt};
    @(posedge clk_sys) #1 sfr_wr = 0;
  endtask
  // read data lives one cycle only, so take it before dropping the strobe
  task rd(logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys) #1;
    {sfr_rd, sfr_addr} = {1'b1, a};
    @(posedge clk_sys) #1 q = sfr_rdata;
    sfr_rd = 0;
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 resetn = 1;
    chk("reset", p, 8'h00);
    chk("reset enables", {6'h00, en}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(8'hF6, 8'h01 << i);
      chk("one bit", p, 8'h01 << i); // to
    end
    $display("test single bits done");
    wr(8'hF6, 8'hA5);
    chk("hit prio", {7'h00, sfr_hit}, 8'h01);
    rd(8'hF6, d);
    chk("read A5", d, 8'hA5);
    wr(8'h55, 8'hFF);
    chk("other address", p, 8'hA5);
    chk("hit other", {7'h00, sfr_hit}, 8'h00);
    rd(8'h55, d);
    chk("unmapped read", d, 8'h00);
    wr(8'hF6, 8'h5A);
    rd(8'hF6, d);
    chk("read 5A", d, 8'h5A);
    wr(8'hE7, 8'hFF);
    rd(8'hE7, d);
    chk("enable read", d, 8'h03);
    chk("enable pins", {6'h00, en}, 8'h03);
    $display("test read back done");
    report_and_stop;
  end
endmodule // extended_interrupt_priority_bank_tb_top
